// >>> rtl/dram_pin_if.sv
`timescale 1ns/10ps
module dram_pin_if
  import dram_pin_pkg::*;
(
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Link clock (true clock of the differential pair)
  input wire logic i_diff_clk_pos,
  // Command pins, link domain
  input wire dram_pin_pkg::cmd_bus_t i_cmd,
  input wire logic i_cke,
  input wire logic i_die_termination_ctl,
  // Part organisation
  input wire logic [1:0] i_org,
  // Write data masks and beats
  input wire logic i_lower_byte_mask,
  input wire logic i_upper_byte_mask,
  input wire logic i_wr_beat,
  // Decoded commands, system domain
  output dram_pin_pkg::dec_cmd_t o_cmd,
  output logic [NBANKS-1:0] o_bank_open,
  output logic [ADDR_W-1:0] o_mode,
  output logic [ADDR_W-1:0] o_ext_mode,
  // Power state and gating
  output dram_pin_pkg::pwr_t o_pwr,
  output logic o_clk_run,
  output logic o_cmd_rx_en,
  output logic o_term_rx_en,
  output logic o_slow_exit,
  // Termination and strobes
  output dram_pin_pkg::rtt_t o_rtt,
  output logic o_strobe_diff,
  output logic o_read_only_strobe_en,
  output logic o_write_mask_in_en,
  output logic o_lower_discard,
  output logic o_upper_discard
);
  // Link-side capture of all address and control pins
  cmd_bus_t lk_cmd_q;
  logic lk_cke_q;
  logic lk_term_q;
  logic lk_tog_q;
  logic [1:0] lk_rx_s_q;
  logic [1:0] lk_trx_s_q;
  dec_cmd_t lk_dec;
  // System-side synchronised copies
  logic [2:0] tog_s_q;
  cmd_bus_t hold_q;
  logic [1:0] cke_s_q;
  logic [1:0] term_s_q;
  logic [1:0] umask_s_q;
  logic [1:0] cke_a_q;
  logic [1:0] mask_s_q;
  logic [1:0] beat_s_q;
  dec_cmd_t dec;
  logic new_cmd;
  pwr_t pwr_q;
  pwr_t pwr_d;
  logic [NBANKS-1:0] open_q;
  logic [ADDR_W-1:0] mode_q;
  logic [ADDR_W-1:0] ext_q;
  logic term_eff;
  rtt_t rtt_sel;

  // Receiver enables come from the system domain: two link flops each,
  // so gating lags a power-state change by a few link cycles.
  always_ff @(posedge i_diff_clk_pos) begin
    if (!i_nrst) begin
      lk_rx_s_q <= 2'h3;
      lk_trx_s_q <= 2'h3;
    end else begin
      lk_rx_s_q <= {lk_rx_s_q[0], o_cmd_rx_en};
      lk_trx_s_q <= {lk_trx_s_q[0], o_term_rx_en};
    end
  end

  // Captured at the rising true clock; receivers for command pins
  // are gated in power-down so a floating bus cannot decode.
  always_ff @(posedge i_diff_clk_pos) begin
    if (!i_nrst) begin
      lk_cmd_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                    default: '0};
      lk_tog_q <= 1'b0;
    end else if (lk_rx_s_q[1] && !i_cmd.cs_n) begin
      lk_cmd_q <= i_cmd;
      lk_tog_q <= ~lk_tog_q;
    end
  end

  always_ff @(posedge i_diff_clk_pos) begin
    if (!i_nrst) begin
      lk_cke_q <= 1'b1;
      lk_term_q <= 1'b0;
    end else begin
      lk_cke_q <= i_cke;
      if (lk_trx_s_q[1]) begin
        lk_term_q <= i_die_termination_ctl;
      end
    end
  end

  // Toggle crossing: only selected commands toggle, and they come at
  // most once per two link cycles, so the captured word stands still
  // for 64 ns while its toggle passes two system flops.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tog_s_q <= 3'h0;
      cke_s_q <= 2'h3;
      term_s_q <= 2'h0;
      mask_s_q <= 2'h0;
      umask_s_q <= 2'h0;
      beat_s_q <= 2'h0;
    end else begin
      tog_s_q <= {tog_s_q[1:0], lk_tog_q};
      cke_s_q <= {cke_s_q[0], lk_cke_q};
      term_s_q <= {term_s_q[0], lk_term_q};
      mask_s_q <= {mask_s_q[0], i_lower_byte_mask};
      umask_s_q <= {umask_s_q[0], i_upper_byte_mask};
      beat_s_q <= {beat_s_q[0], i_wr_beat};
    end
  end

  // Self refresh exit watches the raw pin, no link clock needed
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cke_a_q <= 2'h0;
    end else begin
      cke_a_q <= {cke_a_q[0], i_cke};
    end
  end

  assign new_cmd = tog_s_q[2] ^ tog_s_q[1];

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      hold_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                  default: '0};
    end else if (tog_s_q[1] ^ tog_s_q[0]) begin
      hold_q <= lk_cmd_q;
    end
  end

  dram_cmd_decode u_dec (
    .i_bus(hold_q),
    .i_org(i_org),
    .o_dec(dec)
  );

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_cmd <= '0;
    end else begin
      o_cmd <= dec;
      o_cmd.valid <= new_cmd && dec.valid;
    end
  end

  // Bank state and mode registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      open_q <= '0;
      mode_q <= MODE_RST;
      ext_q <= EXT_RST;
    end else if (new_cmd && dec.valid) begin
      case (dec.cmd)
        CMD_ACT: open_q[dec.bank] <= 1'b1;
        CMD_PRE: begin
          if (dec.pre_all) begin
            open_q <= '0;
          end else begin
            open_q[dec.bank] <= 1'b0;
          end
        end
        CMD_RD, CMD_WR: begin
          if (dec.auto_pre) begin
            open_q[dec.bank] <= 1'b0;
          end
        end
        CMD_MODE_LOAD: begin
          if (dec.bank == MR_SEL) begin
            mode_q <= hold_q.addr;
          end else if (dec.bank == EMR1_SEL) begin
            ext_q <= hold_q.addr;
          end
        end
        default: open_q <= open_q;
      endcase
    end
  end

  // Power state
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PS_ACTIVE: begin
        // Both copies low: after a clock-less wake the link copy is stale
        if (!cke_s_q[1] && !cke_a_q[1]) begin
          if (open_q != '0) begin
            pwr_d = PS_ACTPD;
          end else if (new_cmd && dec.valid && dec.cmd == CMD_REF) begin
            pwr_d = PS_SELFREF;
          end else begin
            pwr_d = PS_PREPD;
          end
        end
      end
      PS_PREPD, PS_ACTPD: begin
        if (pwr_q == PS_PREPD && new_cmd && dec.valid
            && dec.cmd == CMD_REF) begin
          pwr_d = PS_SELFREF;
        end else if (cke_s_q[1]) begin
          pwr_d = PS_ACTIVE;
        end
      end
      PS_SELFREF: begin
        if (cke_a_q[1]) begin
          pwr_d = PS_ACTIVE;
        end
      end
      default: pwr_d = PS_ACTIVE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pwr_q <= PS_ACTIVE;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // Termination
  always_comb begin
    rtt_sel = rtt_t'({ext_q[RTT_HI_BIT], ext_q[RTT_LO_BIT]});
    term_eff = term_s_q[1] && (rtt_sel != RTT_OFF);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rtt <= RTT_OFF;
    end else begin
      o_rtt <= term_eff && pwr_q != PS_SELFREF ? rtt_sel : RTT_OFF;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pwr <= PS_ACTIVE;
      o_clk_run <= 1'b1;
      o_cmd_rx_en <= 1'b1;
      o_term_rx_en <= 1'b1;
      o_slow_exit <= 1'b0;
      o_bank_open <= '0;
      o_mode <= MODE_RST;
      o_ext_mode <= EXT_RST;
    end else begin
      o_pwr <= pwr_d;
      o_clk_run <= pwr_d == PS_ACTIVE;
      o_cmd_rx_en <= pwr_d == PS_ACTIVE;
      o_term_rx_en <= pwr_d != PS_SELFREF;
      o_slow_exit <= mode_q[SLOW_EXIT_BIT];
      o_bank_open <= open_q;
      o_mode <= mode_q;
      o_ext_mode <= ext_q;
    end
  end

  // Strobe modes and write masking
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_strobe_diff <= 1'b1;
      o_read_only_strobe_en <= 1'b0;
      o_write_mask_in_en <= 1'b1;
      o_lower_discard <= 1'b0;
      o_upper_discard <= 1'b0;
    end else begin
      o_strobe_diff <= !ext_q[STROBE_SE_BIT];
      o_read_only_strobe_en <= i_org == ORG_X8 && ext_q[RSTB_EN_BIT];
      o_write_mask_in_en <= !(i_org == ORG_X8
                              && ext_q[RSTB_EN_BIT]);
      o_lower_discard <= beat_s_q[1] && mask_s_q[1]
                         && o_write_mask_in_en;
      o_upper_discard <= beat_s_q[1] && i_org == ORG_X16
                         && umask_s_q[1];
    end
  end

  // p_sr_exit: async gate high leaves self refresh within 3 cycles
  property p_sr_exit;
    @(posedge i_clk) disable iff (!i_nrst)
      (pwr_q == PS_SELFREF && i_cke) |-> ##[1:3] pwr_q == PS_ACTIVE;
  endproperty
  a_sr_exit: assert property (p_sr_exit)
    else $error("self refresh not left");

  property p_pd_kind;
    @(posedge i_clk) disable iff (!i_nrst)
      (pwr_q == PS_ACTIVE && !cke_s_q[1] && !cke_a_q[1]
       && open_q != '0) |=>
        pwr_q == PS_ACTPD;
  endproperty
  a_pd_kind: assert property (p_pd_kind)
    else $error("wrong power-down kind");

  property p_rtt_off;
    @(posedge i_clk) disable iff (!i_nrst)
      (!ext_q[RTT_HI_BIT] && !ext_q[RTT_LO_BIT]) [*2] |-> o_rtt == RTT_OFF;
  endproperty
  a_rtt_off: assert property (p_rtt_off)
    else $error("termination while disabled");

  property p_clk_gate;
    @(posedge i_clk) disable iff (!i_nrst)
      $changed(pwr_q) |-> o_clk_run == (pwr_q == PS_ACTIVE);
  endproperty
  a_clk_gate: assert property (p_clk_gate)
    else $error("clock run mismatch");

  property p_cs_mask;
    @(posedge i_clk) disable iff (!i_nrst)
      (new_cmd && hold_q.cs_n) |=> !o_cmd.valid;
  endproperty
  a_cs_mask: assert property (p_cs_mask)
    else $error("deselected command passed");

  property p_pre_all;
    @(posedge i_clk) disable iff (!i_nrst)
      (new_cmd && dec.valid && dec.cmd == CMD_PRE && dec.pre_all) |=>
        open_q == '0;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge all left a bank open");

  property p_read_only_strobe_mask;
    @(posedge i_clk) disable iff (!i_nrst)
      o_read_only_strobe_en |-> !o_write_mask_in_en;
  endproperty
  a_read_only_strobe_mask: assert property (p_read_only_strobe_mask)
    else $error("mask active with read strobe");

  property p_act_open;
    @(posedge i_clk) disable iff (!i_nrst)
      (new_cmd && dec.valid && dec.cmd == CMD_ACT) |=> open_q[$past(dec.bank)];
  endproperty
  a_act_open: assert property (p_act_open)
    else $error("activate did not open bank");

  property p_desel_hold;
    @(posedge i_diff_clk_pos) disable iff (!i_nrst)
      i_cmd.cs_n |=> $stable(lk_tog_q);
  endproperty
  a_desel_hold: assert property (p_desel_hold)
    else $error("deselected command captured");

  property p_rx_gate;
    @(posedge i_diff_clk_pos) disable iff (!i_nrst)
      !lk_rx_s_q[1] |=> $stable(lk_tog_q);
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("command taken while receivers off");
endmodule

// >>> common/dram_pin_pkg.sv
// How it works
// - Sample command pins on rising link clock
// - Read data on both clock edges
// - Clock gate low stops clocks and drivers
// - Gate low: idle gives precharge/self refresh, open gives active
// - Gate sampled synchronously; self refresh exit asynchronous
// - Power-down/self refresh disable most receivers
// - Chip select high masks every command
// - Command from row, column, write strobes, select
// - Termination control high applies termination
// - Termination disabled by extended mode ignores control
// - Mask high discards write beat
// - x8 mask pin is mask or read strobe
// - Read strobe mirrors main strobe, masking off
// - Bank bits pick bank or mode register
// - Bit 10 on precharge: one or all
// - Row on activate, column on read/write
// - Read strobe edge-aligned, write strobe centred
// - x16 lower strobe low byte, upper high
// - Extended bit 10 sets single-ended strobes
// - Extended bit 11 enables read strobe
// - Four banks, fourteen or thirteen row bits
// - Column bits A0-A9 plus A11 on x4
// - Extended bits 6,2 select termination value
// - Mode bit 12 selects power-down exit speed
package dram_pin_pkg;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 2;
  localparam int NBANKS = 4;
  localparam int ROW_W_X8 = 14;
  localparam int ROW_W_X16 = 13;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;
  localparam int STROBE_SE_BIT = 10;
  localparam int RSTB_EN_BIT = 11;
  localparam int RTT_HI_BIT = 6;
  localparam int RTT_LO_BIT = 2;
  localparam int SLOW_EXIT_BIT = 12;
  localparam int COL_HI_BIT = 11;
  localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;
  localparam logic [ADDR_W-1:0] EXT_RST = 14'h0000;
  localparam logic [1:0] ORG_X4 = 2'h0;
  localparam logic [1:0] ORG_X8 = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;
  localparam logic [1:0] MR_SEL = 2'h0;
  localparam logic [1:0] EMR1_SEL = 2'h1;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h7, CMD_ACT = 3'h3, CMD_RD = 3'h5, CMD_WR = 3'h4,
    CMD_PRE = 3'h2, CMD_REF = 3'h1, CMD_MODE_LOAD = 3'h0, CMD_BST = 3'h6
  } cmd_t;

  typedef enum logic [1:0] {
    RTT_OFF = 2'h0, RTT_75 = 2'h1, RTT_150 = 2'h2, RTT_50 = 2'h3
  } rtt_t;

  typedef enum logic [2:0] {
    PS_ACTIVE = 3'h0, PS_PREPD = 3'h1, PS_ACTPD = 3'h3, PS_SELFREF = 3'h2
  } pwr_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } cmd_bus_t;

  typedef struct packed {
    logic valid;
    cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W:0] col;
    logic auto_pre;
    logic pre_all;
  } dec_cmd_t;
endpackage

// >>> rtl/dram_cmd_decode.sv
`timescale 1ns/10ps
module dram_cmd_decode
  import dram_pin_pkg::*;
(
  // Sampled pins
  input wire dram_pin_pkg::cmd_bus_t i_bus,
  input wire logic [1:0] i_org,
  // Decoded command
  output dram_pin_pkg::dec_cmd_t o_dec
);
  always_comb begin
    o_dec = '0;
    o_dec.cmd = cmd_t'({i_bus.ras_n, i_bus.cas_n, i_bus.we_n});
    o_dec.valid = !i_bus.cs_n;
    o_dec.bank = i_bus.bank;
    if (i_org == ORG_X16) begin
      o_dec.row = {1'b0, i_bus.addr[ROW_W_X16-1:0]};
    end else begin
      o_dec.row = i_bus.addr;
    end
    o_dec.col[COL_W-1:0] = i_bus.addr[COL_W-1:0];
    o_dec.col[COL_W] = (i_org == ORG_X4) ? i_bus.addr[COL_HI_BIT] : 1'b0;
    o_dec.auto_pre = i_bus.addr[AP_BIT];
    o_dec.pre_all = i_bus.addr[AP_BIT];
  end
endmodule

// >>> testbench/ctrl_model.sv
`timescale 1ns/10ps
module ctrl_model
  import dram_pin_pkg::*;
(
  // Link clock
  input wire logic i_clk,
  // Command pins
  output dram_pin_pkg::cmd_bus_t o_cmd,
  output logic o_cke
);
  initial begin
    o_cmd = '1;
    o_cke = 1'b1;
  end

  // Launch just after a crossing so pins sit still around the next one
  task automatic send(input cmd_bus_t c, input logic ke);
    @(posedge i_clk);
    o_cmd <= c;
    o_cke <= ke;
    @(posedge i_clk);
    // Deselect with a flipped pattern so a stale command cannot slip in
    o_cmd <= {1'b1, ~c[18:0]};
    @(posedge i_clk);
  endtask

  // Self refresh exit must work with the link clock stopped
  task automatic wake();
    o_cke <= 1'b1;
  endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/10ps
module tb;
  import dram_pin_pkg::*;
  typedef struct {
    cmd_t k;
    logic [1:0] b;
    logic [13:0] a;
    logic [13:0] f;
    logic [3:0] open;
  } row_t;
  logic i_clk, i_nrst, lk, lk_run, term, lmask, umask, beat, cke;
  logic clk_run, cmd_rx, term_rx, slow, sdiff, rds_en, wmask_en, ldis, udis;
  cmd_bus_t cmd;
  dec_cmd_t dec;
  logic [3:0] bank_open;
  logic [13:0] mode, ext;
  pwr_t pwr;
  rtt_t rtt;
  int miscompares, checks_done, vcnt, v0;
  row_t rows[9];

  ctrl_model ctrl_model_inst (.i_clk(lk), .o_cmd(cmd), .o_cke(cke));
  dram_pin_if dram_pin_if_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_diff_clk_pos(lk), .i_cmd(cmd), .i_cke(cke),
    .i_die_termination_ctl(term), .i_org(ORG_X8),
    .i_lower_byte_mask(lmask), .i_upper_byte_mask(umask),
    .i_wr_beat(beat), .o_cmd(dec), .o_bank_open(bank_open),
    .o_mode(mode), .o_ext_mode(ext), .o_pwr(pwr), .o_clk_run(clk_run),
    .o_cmd_rx_en(cmd_rx), .o_term_rx_en(term_rx), .o_slow_exit(slow),
    .o_rtt(rtt), .o_strobe_diff(sdiff), .o_read_only_strobe_en(rds_en),
    .o_write_mask_in_en(wmask_en), .o_lower_discard(ldis),
    .o_upper_discard(udis));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // Link clock free-running but can be stopped for self refresh
  initial begin
    lk = 1'b0;
    #7;
    forever #16 if (lk_run) lk = ~lk;
  end
  always @(posedge i_clk) if (dec.valid === 1'b1) vcnt <= vcnt + 1;

  task automatic stop_test();
    $display("Counts: %0d checks, %0d mismatches", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (!ok) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic go(logic cs, cmd_t k, logic [1:0] b, logic [13:0] a,
                    logic ke);
    ctrl_model_inst.send({cs, k, b, a}, ke);
    tick(10);
  endtask
  function automatic logic [13:0] got(cmd_t k, logic [1:0] b);
    case (k)
      CMD_ACT: return dec.row;
      CMD_RD, CMD_WR: return {2'h0, dec.auto_pre, dec.col};
      CMD_PRE: return {13'h0, dec.pre_all};
      CMD_MODE_LOAD: return b[0] ? ext : mode;
      default: return 14'h0;
    endcase
  endfunction

  initial begin
    #100us;
    miscompares++;
    stop_test();
  end

  initial begin
    {i_nrst, term, lmask, umask, beat} = '0;
    lk_run = 1'b1;
    rows = '{'{CMD_ACT, 2, 14'h3a5c, 14'h3a5c, 4'h4},
      '{CMD_ACT, 0, 14'h0001, 14'h0001, 4'h5},
      '{CMD_WR, 2, 14'h0155, 14'h0155, 4'h5},
      '{CMD_PRE, 2, 14'h0000, 14'h0000, 4'h1},
      '{CMD_RD, 0, 14'h0caa, 14'h08aa, 4'hx},
      '{CMD_PRE, 1, 14'h0400, 14'h0001, 4'h0},
      '{CMD_REF, 0, 14'h0000, 14'h0000, 4'h0},
      '{CMD_MODE_LOAD, 0, 14'h1000, 14'h1000, 4'h0},
      '{CMD_MODE_LOAD, 1, 14'h0c40, 14'h0c40, 4'h0}};
    tick(4);
    chk(pwr === PS_ACTIVE && clk_run === 1'b1 && sdiff === 1'b1, "rst");
    chk(bank_open === 4'h0 && ext === EXT_RST && wmask_en === 1'b1, "rst2");
    @(posedge i_clk) i_nrst <= 1'b1;
    repeat (4) @(posedge lk);
    $display("reset test done");
    foreach (rows[i]) begin
      v0 = vcnt;
      go(1'b0, rows[i].k, rows[i].b, rows[i].a, 1'b1);
      chk(vcnt == v0 + 1 && dec.cmd === rows[i].k, "cmd");
      chk(dec.bank === rows[i].b, "bank");
      chk(got(rows[i].k, rows[i].b) === rows[i].f, "field");
      if (!$isunknown(rows[i].open))
        chk(bank_open === rows[i].open, "open");
    end
    chk(slow === 1'b1 && sdiff === 1'b0 && rds_en === 1'b1, "ext");
    chk(wmask_en === 1'b0 && rtt === RTT_OFF, "ext2");
    $display("command table done");
    for (int i = 0; i < 4; i++) begin
      go(1'b0, CMD_MODE_LOAD, 2'h1, {7'h0, i[1], 3'h0, i[0], 2'h0}, 1'b1);
      @(posedge i_clk) term <= 1'b1;
      tick(8);
      chk(rtt === rtt_t'(i[1:0]), "rtt on");
      @(posedge i_clk) term <= 1'b0;
      tick(8);
      chk(rtt === RTT_OFF, "rtt off");
    end
    chk(sdiff === 1'b1 && wmask_en === 1'b1, "strobe");
    @(posedge i_clk) {lmask, beat} <= 2'h3;
    tick(3);
    chk(ldis === 1'b1 && udis === 1'b0, "discard");
    go(1'b0, CMD_MODE_LOAD, 2'h1, 14'h0800, 1'b1);
    chk(rds_en === 1'b1 && ldis === 1'b0, "mask off");
    @(posedge i_clk) {lmask, beat} <= 2'h0;
    $display("termination and mask test done");
    v0 = vcnt;
    go(1'b1, CMD_ACT, 2'h3, 14'h0000, 1'b1);
    chk(vcnt == v0 && bank_open === 4'h0, "deselect");
    go(1'b0, CMD_ACT, 2'h1, 14'h0000, 1'b1);
    go(1'b1, CMD_NOP, 2'h0, 14'h0000, 1'b0);
    chk(pwr === PS_ACTPD && clk_run === 1'b0, "act pd");
    chk(cmd_rx === 1'b0 && term_rx === 1'b1, "pd rx");
    v0 = vcnt;
    go(1'b0, CMD_ACT, 2'h2, 14'h0000, 1'b0);
    chk(vcnt == v0, "pd ignore");
    go(1'b1, CMD_NOP, 2'h0, 14'h0000, 1'b1);
    chk(pwr === PS_ACTIVE && clk_run === 1'b1, "pd exit");
    go(1'b0, CMD_PRE, 2'h0, 14'h0400, 1'b1);
    go(1'b1, CMD_NOP, 2'h0, 14'h0000, 1'b0);
    chk(pwr === PS_PREPD, "pre pd");
    go(1'b1, CMD_NOP, 2'h0, 14'h0000, 1'b1);
    go(1'b0, CMD_REF, 2'h0, 14'h0000, 1'b0);
    chk(pwr === PS_SELFREF && term_rx === 1'b0, "self ref");
    lk_run = 1'b0;
    ctrl_model_inst.wake();
    tick(10);
    chk(pwr === PS_ACTIVE, "sr exit");
    lk_run = 1'b1;
    $display("power test done");
    stop_test();
  end
endmodule
